// ---- include/acsr_pkg.sv ----
// shared constants and types for the converter cycle and serial readout
package acsr_pkg;
  localparam int RESULT_W = 16;
  localparam int RAW_W = 18;
  localparam int PTR_W = 5;
  localparam int TIMER_W = 21;
  localparam logic [PTR_W-1:0] BITS_PER_FRAME = 5'h10;
  localparam logic [3:0] TOP_BIT = 4'hf;
  localparam logic [RESULT_W-1:0] RESULT_MIN = 16'h0000;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 16'hffff;
  localparam logic signed [RAW_W-1:0] RAW_MAX = 18'sh0ffff;
  localparam logic signed [RAW_W-1:0] RAW_MIN = 18'sh00000;
  localparam real CLK_MHZ = 100.0;
  localparam real POR_TIME_MS = 0.5;
  localparam real CONV_TIME_MS = 16.6;
  localparam int POR_CYCLES_DEF = int'(POR_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int CONV_CYCLES_DEF = int'(CONV_TIME_MS * 1000.0 * CLK_MHZ);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 21'h000000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 21'h000001;

  typedef enum logic [1:0] {
    st_por,
    st_convert,
    st_sleep,
    st_output
  } acsr_state_t;

  typedef struct packed {
    logic data;
    logic oe;
  } acsr_sdo_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
  } acsr_pins_t;
endpackage

// ---- core/acsr_sync.sv ----
// two flip-flop synchroniser of parameterised width
`timescale 1ns/1ps
module acsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acsr_sync_t;

  acsr_sync_t cur;
  acsr_sync_t next_cur;

  always_comb
  begin
    next_cur.s1 = d;
    next_cur.s2 = cur.s1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cur <= {RST, RST};
    else
      cur <= next_cur;
  end

  assign q = cur.s2;
endmodule

// ---- core/acsr_sck_count.sv ----
// serial clock falling edge counter with gray coded output
`timescale 1ns/1ps
module acsr_sck_count
  import acsr_pkg::*;
(
  input wire logic sck,
  input wire logic nrst,
  output logic [acsr_pkg::PTR_W-1:0] gray
);
  import acsr_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] bin;
    logic [PTR_W-1:0] gray;
  } acsr_cnt_t;

  acsr_cnt_t cur;
  acsr_cnt_t next_cur;

  // one step per falling edge
  always_comb
  begin
    next_cur.bin = cur.bin + 1'b1;
    next_cur.gray = next_cur.bin ^ (next_cur.bin >> 1);
  end

  always_ff @(negedge sck or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign gray = cur.gray;
endmodule

// ---- core/acsr_core.sv ----
// converter cycle sequencer with serial result readout
`timescale 1ns/1ps
module acsr_core
  import acsr_pkg::*;
#(
  parameter logic [acsr_pkg::TIMER_W-1:0] POR_CYCLES =
    acsr_pkg::TIMER_W'(acsr_pkg::POR_CYCLES_DEF),
  parameter logic [acsr_pkg::TIMER_W-1:0] CONV_CYCLES =
    acsr_pkg::TIMER_W'(acsr_pkg::CONV_CYCLES_DEF)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic signed [acsr_pkg::RAW_W-1:0] raw_sample,
  output acsr_pkg::acsr_sdo_t sdo,
  output logic low_power,
  output logic converting
);
  import acsr_pkg::*;

  typedef struct packed {
    acsr_state_t state;
    logic [TIMER_W-1:0] timer;
    logic [RESULT_W-1:0] result;
    logic [PTR_W-1:0] base;
    logic sdo;
    logic sdo_oe;
    logic cs_high_prev;
  } acsr_core_st_t;

  acsr_core_st_t cur;
  acsr_core_st_t next_cur;
  acsr_pins_t pins_raw;
  acsr_pins_t pins_s;
  logic [PTR_W-1:0] ptr_gray;
  logic [PTR_W-1:0] ptr_gray_s;
  logic [PTR_W-1:0] ptr_bin;
  logic [PTR_W-1:0] delta;
  logic cs_low;
  logic sck_low;
  logic cs_rise;
  logic [3:0] bit_idx;

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // clamp the modulator value to the code range
  function automatic logic [RESULT_W-1:0] clamp(
    input logic signed [RAW_W-1:0] v
  );
    logic [RESULT_W-1:0] r;
    r = RESULT_MIN;
    if (v < RAW_MIN)
      r = RESULT_MIN;
    else if (v > RAW_MAX)
      r = RESULT_MAX;
    else
      r = v[RESULT_W-1:0];
    return r;
  endfunction

  assign pins_raw.cs_n = cs_n;
  assign pins_raw.sck = sck;

  // pins reset to idle high, no false select after reset
  acsr_sync #(
    .W(2),
    .RST('1)
  ) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  acsr_sck_count u_edges (
    .sck(sck),
    .nrst(nrst),
    .gray(ptr_gray)
  );

  acsr_sync #(
    .W(PTR_W)
  ) u_ptr_sync (
    .clk(clk),
    .nrst(nrst),
    .d(ptr_gray),
    .q(ptr_gray_s)
  );

  assign ptr_bin = gray2bin(ptr_gray_s);
  assign delta = ptr_bin - cur.base;
  assign cs_low = !pins_s.cs_n;
  assign sck_low = !pins_s.sck;
  assign cs_rise = pins_s.cs_n && !cur.cs_high_prev;
  assign bit_idx = TOP_BIT - delta[3:0];

  always_comb
  begin
    next_cur = cur;
    next_cur.cs_high_prev = pins_s.cs_n;
    next_cur.sdo_oe = cs_low;
    case (cur.state)
      st_por:
      begin
        if (cur.timer >= POR_CYCLES - TIMER_ONE)
        begin
          next_cur.state = st_convert;
          next_cur.timer = TIMER_ZERO;
        end
        else
          next_cur.timer = cur.timer + TIMER_ONE;
      end
      st_convert:
      begin
        if (cur.timer >= CONV_CYCLES - TIMER_ONE)
        begin
          next_cur.state = st_sleep;
          next_cur.timer = TIMER_ZERO;
          next_cur.result = clamp(raw_sample);
        end
        else
          next_cur.timer = cur.timer + TIMER_ONE;
      end
      st_sleep:
      begin
        if (cs_low && sck_low)
        begin
          next_cur.state = st_output;
          next_cur.base = ptr_bin;
        end
      end
      st_output:
      begin
        if (cs_rise || delta >= BITS_PER_FRAME)
        begin
          next_cur.state = st_convert;
          next_cur.timer = TIMER_ZERO;
        end
      end
      default:
        next_cur.state = st_por;
    endcase
    case (cur.state)
      st_convert:
        next_cur.sdo = 1'b1;
      st_output:
        next_cur.sdo = cur.result[bit_idx];
      default:
        next_cur.sdo = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur.state <= st_por;
      cur.timer <= TIMER_ZERO;
      cur.result <= RESULT_MIN;
      cur.base <= '0;
      cur.sdo <= 1'b0;
      cur.sdo_oe <= 1'b0;
      cur.cs_high_prev <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign sdo.data = cur.sdo;
  assign sdo.oe = cur.sdo_oe;
  assign low_power = (cur.state == st_sleep) && pins_s.cs_n;
  assign converting = (cur.state == st_convert);

  a_por_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_por && cur.timer < POR_CYCLES - TIMER_ONE)
    |=> cur.state == st_por)
    else $error("left reset hold early");

  a_por_next: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_por)
    |=> cur.state inside {st_por, st_convert})
    else $error("reset hold not followed by conversion");

  a_conv_fixed: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(cur.state == st_convert)
    |-> (cur.state == st_convert)[*4])
    else $error("conversion cut short");

  a_conv_no_abort: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && cur.timer < CONV_CYCLES - TIMER_ONE)
    |=> cur.state == st_convert)
    else $error("conversion left before its count");

  a_timer_count: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && cur.timer < CONV_CYCLES - TIMER_ONE)
    |=> cur.timer == $past(cur.timer) + TIMER_ONE)
    else $error("conversion count did not advance");

  a_conv_end: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && cur.timer == CONV_CYCLES - TIMER_ONE)
    |=> cur.state == st_sleep)
    else $error("conversion count did not end conversion");

  a_conv_next: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert)
    |=> cur.state inside {st_convert, st_sleep})
    else $error("conversion left in wrong order");

  a_cycle_order: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep)
    |=> cur.state inside {st_sleep, st_output})
    else $error("sleep left in wrong order");

  a_output_next: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output)
    |=> cur.state inside {st_output, st_convert})
    else $error("output left in wrong order");

  a_enter_output: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep && cs_low && sck_low)
    |=> cur.state == st_output)
    else $error("output not entered");

  a_sleep_wait: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep && !(cs_low && sck_low))
    |=> cur.state == st_sleep)
    else $error("sleep left without select and clock low");

  a_power_enter: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep && pins_s.cs_n)
    |-> low_power)
    else $error("no low power while deselected in sleep");

  a_power_wake: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep && cs_low)
    |-> !low_power)
    else $error("low power kept with select low");

  a_hold_result: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep)
    |=> $stable(cur.result))
    else $error("result changed during sleep");

  a_result_stable: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state != st_convert)
    |=> $stable(cur.result))
    else $error("result changed outside conversion end");

  a_top_bit: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output && delta == '0)
    |=> sdo.data == $past(cur.result[RESULT_W-1]))
    else $error("top bit not presented");

  a_shift_bit: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output)
    |=> sdo.data == $past(cur.result[bit_idx]))
    else $error("output bit not the indexed result bit");

  a_frame_end: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output && delta == BITS_PER_FRAME)
    |=> cur.state == st_convert)
    else $error("frame did not end at sixteen edges");

  a_frame_stay: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output && !cs_rise && delta < BITS_PER_FRAME)
    |=> cur.state == st_output)
    else $error("frame ended early");

  a_cs_abort: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_output && cs_rise)
    |=> cur.state == st_convert)
    else $error("select rise did not abort");

  a_oe_select: assert property (
    @(posedge clk) disable iff (!nrst)
    pins_s.cs_n
    |=> !sdo.oe)
    else $error("output driven with select high");

  a_oe_follow: assert property (
    @(posedge clk) disable iff (!nrst)
    cs_low
    |=> sdo.oe)
    else $error("output not driven with select low");

  a_status_busy: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && $past(cur.state) == st_convert)
    |-> sdo.data)
    else $error("status not high while converting");

  a_status_done: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_sleep && $past(cur.state) == st_sleep)
    |-> !sdo.data)
    else $error("status not low after conversion");

  a_clamp_low: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && next_cur.state == st_sleep
     && raw_sample < RAW_MIN)
    |=> cur.result == RESULT_MIN)
    else $error("underrange not clamped");

  a_clamp_high: assert property (
    @(posedge clk) disable iff (!nrst)
    (cur.state == st_convert && next_cur.state == st_sleep
     && raw_sample > RAW_MAX)
    |=> cur.result == RESULT_MAX)
    else $error("overrange not clamped");
endmodule

// ---- sim/acsr_host.sv ----
// host model: drives select and serial clock, captures data
`timescale 1ns/1ps
module acsr_host (
  input wire logic lclk,
  input wire logic sdo,
  output logic cs_n,
  output logic sck
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b1;
  end
  // half period of nine link clocks keeps both sck phases above 250 ns
  task automatic half();
    repeat (9) @(posedge lclk);
  endtask
  task automatic frame(input int nb, output logic [15:0] w,
    output logic last);
    w = 16'h0000;
    sck <= 1'b0;
    half();
    cs_n <= 1'b0;
    half();
    for (int i = 0; i < nb; i++)
    begin
      sck <= 1'b1;
      w = {w[14:0], sdo};
      half();
      sck <= 1'b0;
      half();
    end
    last = sdo;
    cs_n <= 1'b1;
    half();
  endtask
  task automatic poll(input logic lvl);
    sck <= 1'b1;
    cs_n <= lvl;
  endtask
endmodule

// ---- sim/adc_cycle_serial_readout_tb_top.sv ----
// self-checking bench for converter cycle and serial readout
`timescale 1ns/1ps
module adc_cycle_serial_readout_tb_top;
  import acsr_pkg::*;
  localparam int CONV_N = 200;
  localparam logic [TIMER_W-1:0] POR_P = 21'h000014;
  localparam logic [TIMER_W-1:0] CONV_P = 21'h0000c8;
  logic clk;
  logic lclk;
  logic nrst;
  logic signed [RAW_W-1:0] raw_sample;
  acsr_sdo_t sdo;
  logic low_power;
  logic converting;
  logic cs_n;
  logic sck;
  wire logic sdo_w;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  assign sdo_w = sdo.oe ? sdo.data : 1'bz;
  acsr_core #(
    .POR_CYCLES(POR_P),
    .CONV_CYCLES(CONV_P)
  ) uut (
    .clk(clk),
    .nrst(nrst),
    .sck(sck),
    .cs_n(cs_n),
    .raw_sample(raw_sample),
    .sdo(sdo),
    .low_power(low_power),
    .converting(converting)
  );
  acsr_host host (
    .lclk(lclk),
    .sdo(sdo_w),
    .cs_n(cs_n),
    .sck(sck)
  );
  task automatic final_report();
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_conv(input logic lvl, output int n);
    n = 0;
    while (converting !== lvl && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_por();
    int n;
    @(negedge clk);
    check({15'h0, sdo_w}, {15'h0, 1'bz});
    repeat (9) @(negedge clk);
    check({15'h0, converting}, 16'h0000);
    host.poll(1'b0);
    wait_conv(1'b1, n);
    check(16'(n > 4 && n < 16), 16'h0001);
    repeat (5) @(negedge clk);
    check({15'h0, sdo_w}, 16'h0001);
    repeat (50) @(negedge clk);
    host.poll(1'b1);
    repeat (3) @(negedge clk);
    host.poll(1'b0);
    wait_conv(1'b0, n);
    check(16'(n + 58 > CONV_N - 5 && n + 58 < CONV_N + 5), 16'h1);
    repeat (5) @(negedge clk);
    check({15'h0, sdo_w}, 16'h0000);
    check({15'h0, low_power}, 16'h0000);
    host.poll(1'b1);
    repeat (5) @(negedge clk);
    check({15'h0, low_power}, 16'h0001);
    check({15'h0, sdo_w}, {15'h0, 1'bz});
  endtask
  // read nb bits, then load the next sample during the new conversion
  task automatic t_read(input logic [15:0] exp, input int nb,
    input logic signed [RAW_W-1:0] nxt);
    logic [15:0] w;
    logic last;
    int n;
    raw_sample = 18'sh2aaaa;
    host.frame(nb, w, last);
    check(w, exp >> (16 - nb));
    check({15'h0, last}, nb == 16 ? 16'h1 : 16'(exp[15 - nb]));
    @(negedge clk);
    check({15'h0, converting}, 16'h0001);
    check({15'h0, sdo_w}, {15'h0, 1'bz});
    raw_sample = nxt;
    wait_conv(1'b0, n);
    check(16'(n > CONV_N - 60 && n < CONV_N - 20), 16'h0001);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    nrst = 1'b0;
    raw_sample = 18'sh0a5c3;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_por();
    t_read(16'ha5c3, 16, 18'sh3fff0);
    t_read(16'h0000, 16, 18'sh1ffff);
    t_read(16'hffff, 4, 18'sh08001);
    t_read(16'h8001, 16, 18'sh0ffff);
    t_read(16'hffff, 16, 18'sh00000);
    final_report();
  end
endmodule
